// ===== verilog/nvms_defs.svh
// constants for the two-wire nonvolatile memory slave
`ifndef NVMS_DEFS_SVH
`define NVMS_DEFS_SVH
`define NVMS_CNT_W 4
`define NVMS_CNT_ZERO 4'h0
`define NVMS_CNT_PRE_ACK 4'h8
`define NVMS_CNT_POST_ACK 4'h9
`define NVMS_TYPE_MSB 7
`define NVMS_TYPE_LSB 4
`define NVMS_SEL_MSB 3
`define NVMS_SEL_LSB 2
`define NVMS_PAGE_BIT 1
`define NVMS_RW_BIT 0
`define NVMS_ADDR_RST 9'h000
`define NVMS_ADDR_LAST 9'h1ff
`define NVMS_ADDR_ONE 9'h001
`define NVMS_BYTE_RST 8'h00
`endif

// ===== verilog/nvms_pkg.sv
// types shared by the two-wire nonvolatile memory slave
package nvms_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV_ADDR,
        ST_WORD_ADDR,
        ST_WR_DATA,
        ST_RD_DATA
    } nvms_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } nvms_line_s;
endpackage : nvms_pkg

// ===== verilog/nvms_i2c_slave.sv
// two-wire serial slave front end with a 512 x 8 byte array
`timescale 1ns/1ps
`include "nvms_defs.svh"

module nvms_i2c_slave #(
    parameter logic [3:0] DEV_TYPE = 4'h5, // arbitrary type code
    parameter int ADDR_W = 9,
    parameter int DEPTH = 512
) (
    // clock, reset, enable
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // two-wire bus, data is open drain
    input wire logic I_SCL,
    input wire logic I_SDA_IN,
    output logic O_SDA_OUT,
    output logic O_SDA_OE,
    // strap pins
    input wire logic [1:0] I_DEVICE_SELECT_PINS,
    input wire logic I_WP,
    // status
    output logic O_ACTIVE,
    output logic [ADDR_W-1:0] O_ADDR
);

    nvms_pkg::nvms_state_e state_q;
    nvms_pkg::nvms_line_s line_meta_q;
    nvms_pkg::nvms_line_s line_sync_q;
    nvms_pkg::nvms_line_s line_prev_q;
    logic [1:0] sel_meta_q;
    logic [1:0] sel_sync_q;
    logic wp_meta_q;
    logic wp_sync_q;
    logic [`NVMS_CNT_W-1:0] cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [ADDR_W-1:0] addr_q;
    logic rw_q;
    logic sda_oe_q;
    logic sda_out_q;
    logic active_q;
    logic [7:0] mem_q [DEPTH];

    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic pre_ack;
    logic post_ack;
    logic dev_hit;
    logic wr_en;
    logic addr_inc;
    logic [7:0] rd_byte;

    // slave address decode against type code and select straps
    function automatic logic addr_match(input logic [7:0] b, input logic [1:0] sel);
        addr_match = (b[`NVMS_TYPE_MSB:`NVMS_TYPE_LSB] == DEV_TYPE) &&
                     (b[`NVMS_SEL_MSB:`NVMS_SEL_LSB] == sel);
    endfunction : addr_match

    // two-stage synchronisers; logic uses the second stage and, for the bus lines, a delayed copy of it
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            line_meta_q <= '{scl: 1'b1, sda: 1'b1};
            line_sync_q <= '{scl: 1'b1, sda: 1'b1};
            line_prev_q <= '{scl: 1'b1, sda: 1'b1};
            sel_meta_q <= 2'h0;
            sel_sync_q <= 2'h0;
            wp_meta_q <= 1'b0;
            wp_sync_q <= 1'b0;
        end else if (I_CE) begin
            line_meta_q <= '{scl: I_SCL, sda: I_SDA_IN};
            line_sync_q <= line_meta_q;
            line_prev_q <= line_sync_q;
            sel_meta_q <= I_DEVICE_SELECT_PINS;
            sel_sync_q <= sel_meta_q;
            wp_meta_q <= I_WP;
            wp_sync_q <= wp_meta_q;
        end
    end

    // bus conditions from synchronised samples
    assign start_det = line_sync_q.scl && line_prev_q.scl &&
                       line_prev_q.sda && !line_sync_q.sda;
    assign stop_det = line_sync_q.scl && line_prev_q.scl &&
                      !line_prev_q.sda && line_sync_q.sda;
    assign scl_rise = line_sync_q.scl && !line_prev_q.scl;
    assign scl_fall = !line_sync_q.scl && line_prev_q.scl;
    assign pre_ack = scl_fall && (cnt_q == `NVMS_CNT_PRE_ACK);
    assign post_ack = scl_fall && (cnt_q == `NVMS_CNT_POST_ACK);
    assign dev_hit = addr_match(rx_q, sel_sync_q);
    assign wr_en = pre_ack && (state_q == nvms_pkg::ST_WR_DATA) && !wp_sync_q;
    assign addr_inc = wr_en || (pre_ack && (state_q == nvms_pkg::ST_RD_DATA));
    assign rd_byte = mem_q[addr_q];

    // sequencer and bit counter; start and stop override everything
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            state_q <= nvms_pkg::ST_IDLE;
            cnt_q <= `NVMS_CNT_ZERO;
        end else if (I_CE) begin
            if (stop_det) begin
                state_q <= nvms_pkg::ST_IDLE;
                cnt_q <= `NVMS_CNT_ZERO;
            end else if (start_det) begin
                state_q <= nvms_pkg::ST_DEV_ADDR;
                cnt_q <= `NVMS_CNT_ZERO;
            end else if (state_q != nvms_pkg::ST_IDLE) begin
                if (scl_rise && cnt_q != `NVMS_CNT_POST_ACK) begin
                    cnt_q <= cnt_q + 4'h1;
                end
                // master left data high in our read acknowledge slot
                if (scl_rise && cnt_q == `NVMS_CNT_PRE_ACK &&
                    state_q == nvms_pkg::ST_RD_DATA && line_sync_q.sda) begin
                    state_q <= nvms_pkg::ST_IDLE;
                end
                if (post_ack) begin
                    cnt_q <= `NVMS_CNT_ZERO;
                    case (state_q)
                        nvms_pkg::ST_DEV_ADDR: begin
                            if (!sda_oe_q) begin
                                state_q <= nvms_pkg::ST_IDLE;
                            end else if (rw_q) begin
                                state_q <= nvms_pkg::ST_RD_DATA;
                            end else begin
                                state_q <= nvms_pkg::ST_WORD_ADDR;
                            end
                        end
                        nvms_pkg::ST_WORD_ADDR: begin
                            state_q <= nvms_pkg::ST_WR_DATA;
                        end
                        nvms_pkg::ST_WR_DATA: begin
                            // no acknowledge given ends the write
                            if (!sda_oe_q) begin
                                state_q <= nvms_pkg::ST_IDLE;
                            end
                        end
                        nvms_pkg::ST_RD_DATA: begin
                            state_q <= nvms_pkg::ST_RD_DATA;
                        end
                        default: begin
                            state_q <= nvms_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // receive shifter, msb first on rising edges
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            rx_q <= `NVMS_BYTE_RST;
        end else if (I_CE) begin
            if (scl_rise && cnt_q < `NVMS_CNT_PRE_ACK) begin
                rx_q <= {rx_q[6:0], line_sync_q.sda};
            end
        end
    end

    // address latch and direction; page bit taken from the slave address
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            addr_q <= `NVMS_ADDR_RST;
            rw_q <= 1'b0;
        end else if (I_CE) begin
            if (pre_ack && state_q == nvms_pkg::ST_DEV_ADDR && dev_hit) begin
                addr_q[ADDR_W-1] <= rx_q[`NVMS_PAGE_BIT];
                rw_q <= rx_q[`NVMS_RW_BIT];
            end else if (pre_ack && state_q == nvms_pkg::ST_WORD_ADDR) begin
                addr_q <= {addr_q[ADDR_W-1], rx_q};
            end else if (addr_inc) begin
                // natural 9-bit overflow gives the 1ff to 000 wrap
                addr_q <= addr_q + `NVMS_ADDR_ONE;
            end
        end
    end

    // array write straight from the shifter, no buffering or busy time
    always_ff @(posedge I_CORE_CLK) begin
        if (I_CE && !I_RST && wr_en) begin
            mem_q[addr_q] <= rx_q;
        end
    end

    // data pin driver; changes only on falling clock or bus conditions
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            sda_oe_q <= 1'b0;
            sda_out_q <= 1'b0;
            tx_q <= `NVMS_BYTE_RST;
        end else if (I_CE) begin
            sda_out_q <= 1'b0; // open drain: only ever pulls low
            if (start_det || stop_det) begin
                sda_oe_q <= 1'b0;
            end else if (scl_fall) begin
                case (state_q)
                    nvms_pkg::ST_DEV_ADDR: begin
                        if (pre_ack) begin
                            sda_oe_q <= dev_hit;
                        end else if (post_ack && sda_oe_q && rw_q) begin
                            tx_q <= rd_byte;
                            sda_oe_q <= !rd_byte[7];
                        end else begin
                            sda_oe_q <= 1'b0;
                        end
                    end
                    nvms_pkg::ST_WORD_ADDR: begin
                        sda_oe_q <= pre_ack;
                    end
                    nvms_pkg::ST_WR_DATA: begin
                        sda_oe_q <= pre_ack && !wp_sync_q;
                    end
                    nvms_pkg::ST_RD_DATA: begin
                        if (pre_ack) begin
                            sda_oe_q <= 1'b0;
                        end else if (post_ack) begin
                            tx_q <= rd_byte;
                            sda_oe_q <= !rd_byte[7];
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            sda_oe_q <= !tx_q[6];
                        end
                    end
                    default: begin
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // status
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            active_q <= 1'b0;
        end else if (I_CE) begin
            active_q <= (state_q != nvms_pkg::ST_IDLE);
        end
    end

    assign O_SDA_OUT = sda_out_q;
    assign O_SDA_OE = sda_oe_q;
    assign O_ACTIVE = active_q;
    assign O_ADDR = addr_q;

    // checks
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST || !I_CE);

    stop_abort_a: assert property (stop_det |=> state_q == nvms_pkg::ST_IDLE && !sda_oe_q)
        else $error("stop did not abort");

    start_ready_a: assert property (start_det |=>
        state_q == nvms_pkg::ST_DEV_ADDR && cnt_q == `NVMS_CNT_ZERO)
        else $error("start did not ready for address");

    pin_timing_a: assert property ($changed(sda_oe_q) |->
        $past(scl_fall || start_det || stop_det))
        else $error("data pin moved outside a falling clock");

    addr_ack_a: assert property (pre_ack && state_q == nvms_pkg::ST_DEV_ADDR |=>
        sda_oe_q == $past(dev_hit))
        else $error("slave address acknowledge wrong");

    addr_wrap_a: assert property (addr_inc && !start_det && !stop_det |=>
        addr_q == $past(addr_q) + `NVMS_ADDR_ONE)
        else $error("address increment or wrap wrong");

    wp_block_a: assert property (pre_ack && wp_sync_q && state_q == nvms_pkg::ST_WR_DATA
        && !start_det && !stop_det |=> !sda_oe_q && $stable(addr_q))
        else $error("protected write was accepted");

    read_nack_a: assert property (scl_rise && line_sync_q.sda
        && cnt_q == `NVMS_CNT_PRE_ACK && state_q == nvms_pkg::ST_RD_DATA
        |=> state_q == nvms_pkg::ST_IDLE)
        else $error("read not ended on no acknowledge");

    write_commit_a: assert property (wr_en |=> mem_q[$past(addr_q)] == $past(rx_q))
        else $error("byte not committed to array");

    word_latch_a: assert property (pre_ack && state_q == nvms_pkg::ST_WORD_ADDR
        && !start_det && !stop_det |=> addr_q[7:0] == $past(rx_q))
        else $error("word address not latched");

    rd_continue_a: assert property (scl_rise && !line_sync_q.sda
        && cnt_q == `NVMS_CNT_PRE_ACK && state_q == nvms_pkg::ST_RD_DATA
        |=> state_q == nvms_pkg::ST_RD_DATA)
        else $error("read did not continue on acknowledge");

    rd_slot_release_a: assert property (pre_ack && state_q == nvms_pkg::ST_RD_DATA
        |=> !sda_oe_q)
        else $error("data pin held in master acknowledge slot");

    wr_ack_release_a: assert property (post_ack && (state_q == nvms_pkg::ST_WORD_ADDR
        || state_q == nvms_pkg::ST_WR_DATA) |=> !sda_oe_q)
        else $error("acknowledge not released after slot");

    no_match_idle_a: assert property (post_ack && state_q == nvms_pkg::ST_DEV_ADDR
        && !sda_oe_q |=> state_q == nvms_pkg::ST_IDLE)
        else $error("unmatched address not ignored");

    idle_quiet_a: assert property (scl_fall && state_q == nvms_pkg::ST_IDLE
        |=> !sda_oe_q)
        else $error("idle device drove the data pin");

    page_latch_a: assert property (pre_ack && dev_hit
        && state_q == nvms_pkg::ST_DEV_ADDR |=> addr_q[ADDR_W-1] == $past(rx_q[`NVMS_PAGE_BIT]))
        else $error("page bit not latched");

    dir_select_a: assert property (post_ack && sda_oe_q
        && state_q == nvms_pkg::ST_DEV_ADDR |=> state_q ==
        ($past(rx_q[`NVMS_RW_BIT]) ? nvms_pkg::ST_RD_DATA : nvms_pkg::ST_WORD_ADDR))
        else $error("direction bit not followed");

    start_release_a: assert property (start_det |=> !sda_oe_q)
        else $error("start did not release the data pin");

endmodule : nvms_i2c_slave

// ===== test/nvms_master_model.sv
// two-wire bus master model that drives the slave's bus pins
`timescale 1ns/1ps

module nvms_master_model (
    // device side of the open-drain data wire
    input wire logic i_sda_oe,
    input wire logic i_sda_out,
    // bus lines as seen on the board
    output logic o_scl,
    output logic o_sda
);
    // quarter of the 200 ns bus period
    localparam time Q = 50ns;
    logic pull_low;

    initial begin
        o_scl = 1'b1;
        pull_low = 1'b0;
    end

    // pulled up unless either party pulls low
    assign o_sda = ~(pull_low | (i_sda_oe & ~i_sda_out));

    // extra low time lets the slave drop its acknowledge before the clock rises
    task automatic start_cond();
        pull_low = 1'b0;
        #(2*Q) o_scl = 1'b1;
        #Q pull_low = 1'b1;
        #Q o_scl = 1'b0;
        #Q;
    endtask : start_cond

    task automatic stop_cond();
        pull_low = 1'b1;
        #Q o_scl = 1'b1;
        #Q pull_low = 1'b0;
        #(2*Q);
    endtask : stop_cond

    // data moves only while the clock is low, sampled mid-high
    task automatic put_bit(input logic b, output logic seen);
        pull_low = ~b;
        #Q o_scl = 1'b1;
        #Q seen = o_sda;
        #Q o_scl = 1'b0;
        #Q;
    endtask : put_bit

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte

    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(~ack, s);
    endtask : get_byte
endmodule : nvms_master_model

// ===== test/tb.sv
// self-checking bench for the two-wire memory slave
`timescale 1ns/1ps

module tb;
    localparam logic [1:0] SEL = 2'b10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp = 1'b0;
    logic sda_oe, sda_out, active, scl, sda;
    logic [8:0] addr;
    int err_total = 0;
    int n_checks = 0;

    always #12.5 clk = ~clk;

    nvms_i2c_slave nvms_i2c_slave_inst (
        .I_CORE_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_SCL(scl), .I_SDA_IN(sda),
        .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_DEVICE_SELECT_PINS(SEL), .I_WP(wp),
        .O_ACTIVE(active), .O_ADDR(addr)
    );

    nvms_master_model nvms_master_model_inst (
        .i_sda_oe(sda_oe), .i_sda_out(sda_out), .o_scl(scl), .o_sda(sda)
    );

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_val(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    function automatic logic [7:0] dev(input logic page, input logic rd);
        return {4'h5, SEL, page, rd};
    endfunction : dev

    // start, slave address and word address, each expected to be acknowledged
    task automatic set_ptr(input logic [8:0] a);
        logic k;
        nvms_master_model_inst.start_cond();
        nvms_master_model_inst.send_byte(dev(a[8], 1'b0), k);
        chk_bit("dev ack", 1'b1, k);
        nvms_master_model_inst.send_byte(a[7:0], k);
        chk_bit("word ack", 1'b1, k);
        chk_val("latch", a, addr);
    endtask : set_ptr

    task automatic rd_one(input logic ack, input logic [7:0] exp);
        logic [7:0] d;
        nvms_master_model_inst.get_byte(ack, d);
        chk_val("read", {1'b0, exp}, {1'b0, d});
    endtask : rd_one

    task automatic t_wrap();
        logic k;
        logic [7:0] v[3] = '{8'ha5, 8'h3c, 8'h81};
        set_ptr(9'h1fe);
        foreach (v[i]) begin
            nvms_master_model_inst.send_byte(v[i], k);
            chk_bit("data ack", 1'b1, k);
        end
        chk_val("wrap", 9'h001, addr);
        set_ptr(9'h1fe);
        nvms_master_model_inst.start_cond();
        nvms_master_model_inst.send_byte(dev(1'b1, 1'b1), k);
        chk_bit("rd dev ack", 1'b1, k);
        rd_one(1'b1, 8'ha5);
        rd_one(1'b1, 8'h3c);
        rd_one(1'b0, 8'h81);
        #100;
        chk_bit("idle after nack", 1'b0, active);
        nvms_master_model_inst.stop_cond();
        $display("test wrap done");
    endtask : t_wrap

    task automatic t_protect();
        logic k;
        set_ptr(9'h010);
        nvms_master_model_inst.send_byte(8'h77, k);
        chk_bit("data ack", 1'b1, k);
        nvms_master_model_inst.stop_cond();
        @(negedge clk) wp = 1'b1;
        #3;
        set_ptr(9'h010);
        nvms_master_model_inst.send_byte(8'h11, k);
        chk_bit("protected ack", 1'b0, k);
        chk_val("protected addr", 9'h010, addr);
        nvms_master_model_inst.stop_cond();
        @(negedge clk) wp = 1'b0;
        #3;
        nvms_master_model_inst.start_cond();
        nvms_master_model_inst.send_byte(dev(1'b0, 1'b1), k);
        chk_bit("rd dev ack", 1'b1, k);
        rd_one(1'b0, 8'h77);
        chk_val("after read", 9'h011, addr);
        nvms_master_model_inst.stop_cond();
        $display("test protect done");
    endtask : t_protect

    task automatic t_abort();
        logic k;
        set_ptr(9'h020);
        nvms_master_model_inst.send_byte(8'h5a, k);
        chk_bit("data ack", 1'b1, k);
        nvms_master_model_inst.stop_cond();
        set_ptr(9'h020);
        for (int i = 0; i < 5; i++) nvms_master_model_inst.put_bit(1'b0, k);
        nvms_master_model_inst.stop_cond();
        #100;
        chk_bit("idle after stop", 1'b0, active);
        nvms_master_model_inst.start_cond();
        for (int i = 0; i < 3; i++) nvms_master_model_inst.put_bit(1'b1, k);
        nvms_master_model_inst.start_cond();
        nvms_master_model_inst.send_byte(dev(1'b0, 1'b1), k);
        chk_bit("restart ack", 1'b1, k);
        rd_one(1'b0, 8'h5a);
        chk_val("after abort", 9'h021, addr);
        nvms_master_model_inst.stop_cond();
        $display("test abort done");
    endtask : t_abort

    task automatic t_mismatch();
        logic k;
        nvms_master_model_inst.start_cond();
        nvms_master_model_inst.send_byte({4'h5, ~SEL, 2'b00}, k);
        chk_bit("wrong select", 1'b0, k);
        nvms_master_model_inst.send_byte(dev(1'b0, 1'b0), k);
        chk_bit("no start", 1'b0, k);
        nvms_master_model_inst.stop_cond();
        nvms_master_model_inst.start_cond();
        nvms_master_model_inst.send_byte({4'h3, SEL, 2'b00}, k);
        chk_bit("wrong type", 1'b0, k);
        nvms_master_model_inst.stop_cond();
        $display("test mismatch done");
    endtask : t_mismatch

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // whole run needs well under 150 us of bus traffic
    initial begin
        #400us;
        err_total++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (4) @(negedge clk);
        #3;
        t_wrap();
        t_protect();
        t_abort();
        t_mismatch();
        report_and_stop();
    end
endmodule : tb
